// [dv/dsp_host_model.sv]
// host side model: issues one taskfile command, then its parameter sector unless the device ends the command at once
// assumes the device takes one word per cycle and ends with a done pulse
`timescale 1ns/1ps
module dsp_host_model (
    input wire logic sys_clk_in,
    input wire logic go_in,
    input wire logic [7:0] op_in,
    input wire logic [15:0] ctl_in,
    input wire logic [15:0] pw_base_in,
    input wire logic bad_in,
    input wire logic [15:0] rev_in,
    input wire logic cmd_done_in,
    input wire logic [7:0] error_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_out,
    output logic data_valid_out,
    output logic [15:0] data_out,
    output logic busy_out,
    output logic pw_fail_out,
    output logic other_fault_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = 8'h00;
        data_valid_out = 1'b0;
        data_out = 16'h0000;
        busy_out = 1'b0;
        pw_fail_out = 1'b0;
        other_fault_out = 1'b0;
    end
    function automatic logic [15:0] word(input int i);
        if (i == 0) return ctl_in;
        // a bad password differs only in its last byte
        if (i <= 16) return pw_base_in ^ 16'(i) ^ ((bad_in && i == 16) ? 16'h8000 : 16'h0);
        if (i == 17) return rev_in;
        return 16'(~i);
    endfunction
    always begin
        @(posedge sys_clk_in);
        if (go_in === 1'b1) begin
            busy_out <= 1'b1;
            pw_fail_out <= 1'b0;
            other_fault_out <= 1'b0;
            cmd_valid_out <= 1'b1;
            cmd_out <= op_in;
            @(posedge sys_clk_in);
            cmd_valid_out <= 1'b0;
            cmd_out <= ~op_in;
            // an early abort stands for one cycle only, right after the command edge
            #1;
            if (cmd_done_in === 1'b1) begin
                other_fault_out <= 1'b1;
            end else begin
                @(posedge sys_clk_in);
                for (int i = 0; i < 256; i++) begin
                    data_valid_out <= 1'b1;
                    data_out <= word(i);
                    @(posedge sys_clk_in);
                end
                data_valid_out <= 1'b0;
                // released lines must not keep the last word
                data_out <= ~word(255);
                for (int i = 0; i < 8; i++) begin
                    @(posedge sys_clk_in);
                    #1;
                    if (cmd_done_in === 1'b1) break;
                end
                pw_fail_out <= error_in[2];
            end
            busy_out <= 1'b0;
        end
    end
endmodule

// [dv/testbench.sv]
// self-checking bench for the password lock handler
// assumes the host model drives the taskfile side
`timescale 1ns/1ps
module testbench;
    logic clk, rst_b, po, hr, go, bad, id_rd, wr, rd;
    logic [7:0] op, id_w, addr, err, st;
    logic [15:0] ctl, pw_base, rev, idd, dat;
    logic [31:0] wd, rdat;
    logic cv, dv, done, lck, busy, pwf, oth;
    logic [7:0] cmd;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    dsp_security dsp_security_i (.sys_clk_in(clk), .rst_b_in(rst_b), .power_on_in(po),
        .hard_reset_in(hr), .cmd_valid_in(cv), .cmd_in(cmd), .data_valid_in(dv),
        .data_in(dat), .ident_rd_in(id_rd), .ident_word_in(id_w), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .ident_data_out(idd),
        .cmd_done_out(done), .error_out(err), .status_out(st), .locked_out(lck));
    dsp_host_model dsp_host_model_i (.sys_clk_in(clk), .go_in(go), .op_in(op),
        .ctl_in(ctl), .pw_base_in(pw_base), .bad_in(bad), .rev_in(rev), .cmd_done_in(done),
        .error_in(err), .cmd_valid_out(cv), .cmd_out(cmd), .data_valid_out(dv),
        .data_out(dat), .busy_out(busy), .pw_fail_out(pwf), .other_fault_out(oth));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        // a full run needs about 5000 cycles
        if (cycles == 30000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("register", e, rdat);
    endtask
    task automatic id_chk(input logic [7:0] w, input logic [15:0] e);
        @(posedge clk);
        id_w <= w;
        id_rd <= 1'b1;
        @(posedge clk);
        id_rd <= 1'b0;
        #1 check("identify word", {16'h0, e}, {16'h0, idd});
    endtask
    task automatic pulse(input bit hard);
        @(posedge clk);
        if (hard) hr <= 1'b1;
        else po <= 1'b1;
        @(posedge clk);
        hr <= 1'b0;
        po <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // runs one command; ab: abort expected, early: abort before the sector
    task automatic issue(input logic [7:0] o, input logic [15:0] c, input logic [15:0] s,
                         input logic b, input logic [15:0] r, input bit ab, input bit early);
        @(posedge clk);
        op <= o;
        ctl <= c;
        pw_base <= s;
        bad <= b;
        rev <= r;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        // locked_out trails the end of the command by one register stage
        @(posedge clk);
        #1;
        check("error flags", ab ? 8'h04 : 8'h00, err);
        check("status flags", ab ? 8'h41 : 8'h40, st);
        check("early abort", early, oth);
        check("mismatch abort", ab && !early, pwf);
    endtask
    task automatic t_reset;
        rd_chk(8'h04, 32'h40);
        rd_chk(8'h00, 32'h00);
        rd_chk(8'h0c, 32'hfffe);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h20, 32'h0);
        id_chk(8'd92, 16'hfffe);
        id_chk(8'd5, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_master;
        issue(8'hf1, 16'h0001, 16'h1111, 1'b0, 16'h1234, 0, 0);
        rd_chk(8'h08, 32'h0);
        id_chk(8'd92, 16'h1234);
        issue(8'hf1, 16'h0101, 16'h1111, 1'b0, 16'hffff, 0, 0);
        id_chk(8'd92, 16'h1234);
        issue(8'hf1, 16'h0001, 16'h1111, 1'b0, 16'h0000, 0, 0);
        id_chk(8'd92, 16'h1234);
        pulse(0);
        check("locked", 1'b0, lck);
        issue(8'hf2, 16'h0000, 16'h2222, 1'b0, 16'h0, 1, 0);
        pulse(0);
        $display("test master done");
    endtask
    task automatic t_user_high;
        issue(8'hf1, 16'h0000, 16'h2222, 1'b0, 16'h5555, 0, 0);
        rd_chk(8'h08, 32'h1);
        id_chk(8'd92, 16'h1234);
        check("locked", 1'b0, lck);
        pulse(0);
        check("locked", 1'b1, lck);
        issue(8'hf2, 16'h0000, 16'h2222, 1'b1, 16'h0, 1, 0);
        check("locked", 1'b1, lck);
        issue(8'hf2, 16'h0001, 16'h1111, 1'b0, 16'h0, 0, 0);
        check("locked", 1'b0, lck);
        pulse(1);
        check("locked", 1'b1, lck);
        issue(8'hf2, 16'h0000, 16'h2222, 1'b0, 16'h0, 0, 0);
        check("locked", 1'b0, lck);
        $display("test user high done");
    endtask
    task automatic t_user_max;
        issue(8'hf1, 16'h0100, 16'h3333, 1'b0, 16'h0, 0, 0);
        pulse(0);
        check("locked", 1'b1, lck);
        issue(8'hf2, 16'h0001, 16'h1111, 1'b0, 16'h0, 1, 0);
        for (int i = 0; i < 4; i++) begin
            issue(8'hf2, 16'h0000, 16'h3333, 1'b1, 16'h0, 1, 0);
        end
        issue(8'hf2, 16'h0000, 16'h3333, 1'b0, 16'h0, 1, 1);
        rd_chk(8'h08, 32'h17);
        pulse(1);
        issue(8'hf2, 16'h0000, 16'h3333, 1'b0, 16'h0, 0, 0);
        check("locked", 1'b0, lck);
        $display("test user max done");
    endtask
    task automatic t_freeze;
        reg_wr(8'h10, 32'h1);
        rd_chk(8'h10, 32'h1);
        issue(8'hf1, 16'h0001, 16'h4444, 1'b0, 16'h0, 1, 1);
        pulse(1);
        issue(8'hf2, 16'h0000, 16'h3333, 1'b0, 16'h0, 1, 1);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(8'h10, 32'h0);
        id_chk(8'h5c, 16'hfffe);
        issue(8'hf1, 16'h0001, 16'h4444, 1'b0, 16'h0, 0, 0);
        issue(8'hf3, 16'h0001, 16'h4444, 1'b0, 16'h0, 0, 0);
        $display("test freeze done");
    endtask
    initial begin
        {rst_b, po, hr, go, bad, id_rd, wr, rd} = 8'h00;
        {op, id_w, addr} = 24'h0;
        {ctl, pw_base, rev} = 48'h0;
        wd = 32'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_master();
        t_user_high();
        t_user_max();
        t_freeze();
        summarize();
    end
endmodule

// [rtl/dsp_pkg.sv]
// constants and types for the drive password lock command handler
// assumes a 16-bit taskfile data port and one 256-word parameter sector
package dsp_pkg;
    localparam logic [7:0] CMD_SET_PASSWORD = 8'hf1;
    localparam logic [7:0] CMD_UNLOCK = 8'hf2;
    localparam int WORDS_PER_SECTOR = 256;
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD = 16;
    localparam int REV_WORD = 17;
    localparam int IDENT_BIT = 0;
    localparam int LEVEL_BIT = 8;
    localparam logic [2:0] ATTEMPT_START = 3'h5;
    localparam logic [15:0] REV_INVALID_LO = 16'h0000;
    localparam logic [15:0] REV_INVALID_HI = 16'hffff;
    localparam logic [15:0] REV_RESET = 16'hfffe;
    localparam int IDENT_REV_WORD = 92;
    localparam int ERR_ABORT_BIT = 2;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_READY_BIT = 6;
    localparam int ST_DRQ_BIT = 3;
    localparam int ST_ERR_BIT = 0;
    localparam logic [7:0] REG_ERROR = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LOCK = 8'h08;
    localparam logic [7:0] REG_REVISION = 8'h0c;
    localparam logic [7:0] REG_FREEZE = 8'h10;
    localparam int LOCK_ENABLED_BIT = 0;
    localparam int LOCK_LOCKED_BIT = 1;
    localparam int LOCK_MAXLVL_BIT = 2;
    localparam int LOCK_FROZEN_BIT = 3;
    localparam int LOCK_EXPIRED_BIT = 4;

    typedef enum logic [1:0] {
        DSP_IDLE = 2'b00,
        DSP_RECV = 2'b01,
        DSP_EXEC = 2'b10
    } dsp_state_t;
endpackage

// [rtl/dsp_pw_compare.sv]
// password compare: 16 words, one word per cycle, all 32 bytes significant
// assumes words arrive in order and start_in marks word 1
`timescale 1ns/1ps
module dsp_pw_compare #(
    parameter int WORDS = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic [15:0] ref_in,
    output logic match_out
);
    // sticky mismatch; cleared at the first word of each block
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_out <= 1'b0;
        end else if (word_valid_in) begin
            if (start_in) begin
                match_out <= (word_in == ref_in);
            end else begin
                match_out <= match_out & (word_in == ref_in);
            end
        end
    end
endmodule

// [rtl/dsp_security.sv]
// drive password lock: set-password and unlock command handling
// assumes command and data words from a taskfile front end, synchronous to sys_clk_in
`timescale 1ns/1ps
module dsp_security (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic power_on_in,
    input wire logic hard_reset_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_in,
    input wire logic data_valid_in,
    input wire logic [15:0] data_in,
    input wire logic ident_rd_in,
    input wire logic [7:0] ident_word_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic [15:0] ident_data_out,
    output logic cmd_done_out,
    output logic [7:0] error_out,
    output logic [7:0] status_out,
    output logic locked_out
);
    dsp_pkg::dsp_state_t state;
    dsp_pkg::dsp_state_t next_state;
    logic is_set;
    logic [7:0] word_idx;
    logic ident_master;
    logic level_max;
    logic [15:0] rev_in;
    logic [15:0] pw_new [0:15];
    logic [15:0] user_pw [0:15];
    logic [15:0] master_pw [0:15];
    logic [15:0] master_rev;
    logic lock_enabled;
    logic locked;
    logic sec_max;
    logic frozen;
    logic [2:0] attempts;
    logic user_match;
    logic master_match;
    logic pw_word;
    logic [3:0] pw_sel;
    logic is_cmd;
    logic reject_early;
    logic do_abort;
    logic unlock_ok;
    logic accepted;

    assign is_cmd = cmd_valid_in && state == dsp_pkg::DSP_IDLE &&
        (cmd_in == dsp_pkg::CMD_SET_PASSWORD || cmd_in == dsp_pkg::CMD_UNLOCK);
    // frozen or expired drives abort before asking for data
    assign reject_early = frozen || attempts == 3'h0;
    assign pw_word = data_valid_in && word_idx >= 8'(dsp_pkg::PW_FIRST_WORD) &&
        word_idx <= 8'(dsp_pkg::PW_LAST_WORD);
    assign pw_sel = 4'(word_idx - 8'h01);

    dsp_pw_compare #(.WORDS(16)) u_cmp_user (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .start_in(word_idx == 8'(dsp_pkg::PW_FIRST_WORD)),
        .word_valid_in(pw_word),
        .word_in(data_in),
        .ref_in(user_pw[pw_sel]),
        .match_out(user_match)
    );

    dsp_pw_compare #(.WORDS(16)) u_cmp_master (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .start_in(word_idx == 8'(dsp_pkg::PW_FIRST_WORD)),
        .word_valid_in(pw_word),
        .word_in(data_in),
        .ref_in(master_pw[pw_sel]),
        .match_out(master_match)
    );

    // unlock decision, evaluated in the exec cycle
    always_comb begin
        unlock_ok = 1'b0;
        if (!ident_master) begin
            unlock_ok = lock_enabled && user_match;
        end else begin
            unlock_ok = !sec_max && master_match;
        end
    end
    assign do_abort = !is_set && !unlock_ok;
    assign accepted = state == dsp_pkg::DSP_EXEC && is_set;

    always_comb begin
        next_state = state;
        case (state)
            dsp_pkg::DSP_IDLE: begin
                if (is_cmd && !reject_early) begin
                    next_state = dsp_pkg::DSP_RECV;
                end
            end
            dsp_pkg::DSP_RECV: begin
                if (data_valid_in && word_idx == 8'(dsp_pkg::WORDS_PER_SECTOR - 1)) begin
                    next_state = dsp_pkg::DSP_EXEC;
                end
            end
            dsp_pkg::DSP_EXEC: next_state = dsp_pkg::DSP_IDLE;
            default: next_state = dsp_pkg::DSP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= dsp_pkg::DSP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture of the parameter sector
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            is_set <= 1'b0;
            word_idx <= 8'h00;
            ident_master <= 1'b0;
            level_max <= 1'b0;
            rev_in <= 16'h0000;
        end else if (is_cmd) begin
            is_set <= cmd_in == dsp_pkg::CMD_SET_PASSWORD;
            word_idx <= 8'h00;
        end else if (state == dsp_pkg::DSP_RECV && data_valid_in) begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == 8'h00) begin
                ident_master <= data_in[dsp_pkg::IDENT_BIT];
                level_max <= data_in[dsp_pkg::LEVEL_BIT] & is_set;
            end
            if (word_idx == 8'(dsp_pkg::REV_WORD)) begin
                rev_in <= data_in;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (state == dsp_pkg::DSP_RECV && pw_word) begin
            pw_new[pw_sel] <= data_in;
        end
    end

    // stored passwords survive resets; only a completed set-password writes them
    always_ff @(posedge sys_clk_in) begin
        if (accepted && !ident_master) begin
            user_pw <= pw_new;
        end
        if (accepted && ident_master) begin
            master_pw <= pw_new;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            master_rev <= dsp_pkg::REV_RESET;
        end else if (accepted && ident_master && rev_in != dsp_pkg::REV_INVALID_LO &&
                     rev_in != dsp_pkg::REV_INVALID_HI) begin
            master_rev <= rev_in;
        end
    end

    // lock enable and level; master set leaves both alone
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lock_enabled <= 1'b0;
            sec_max <= 1'b0;
        end else if (accepted && !ident_master) begin
            lock_enabled <= 1'b1;
            sec_max <= level_max;
        end
    end

    // locked state follows power-on/hard reset; unlock clears it
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            locked <= 1'b0;
        end else if (power_on_in || hard_reset_in) begin
            locked <= lock_enabled;
        end else if (state == dsp_pkg::DSP_EXEC && !is_set && unlock_ok) begin
            locked <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            attempts <= dsp_pkg::ATTEMPT_START;
        end else if (power_on_in || hard_reset_in) begin
            attempts <= dsp_pkg::ATTEMPT_START;
        end else if (state == dsp_pkg::DSP_EXEC && do_abort && attempts != 3'h0) begin
            attempts <= attempts - 3'h1;
        end
    end

    // frozen is set by software and left only by power-on or rst_b_in
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frozen <= 1'b0;
        end else if (power_on_in) begin
            frozen <= 1'b0;
        end else if (wr_in && addr_in == dsp_pkg::REG_FREEZE && wdata_in[0]) begin
            frozen <= 1'b1;
        end
    end

    // taskfile error and status, plus completion pulse
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            error_out <= 8'h00;
            status_out <= 8'h40;
            cmd_done_out <= 1'b0;
        end else begin
            cmd_done_out <= 1'b0;
            if (is_cmd && reject_early) begin
                error_out <= 8'h01 << dsp_pkg::ERR_ABORT_BIT;
                status_out <= 8'h41;
                cmd_done_out <= 1'b1;
            end else if (is_cmd) begin
                error_out <= 8'h00;
                status_out <= 8'h48;
            end else if (state == dsp_pkg::DSP_EXEC) begin
                cmd_done_out <= 1'b1;
                if (do_abort) begin
                    error_out <= 8'h01 << dsp_pkg::ERR_ABORT_BIT;
                    status_out <= 8'h41;
                end else begin
                    status_out <= 8'h40;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            locked_out <= 1'b0;
            ident_data_out <= 16'h0000;
        end else begin
            locked_out <= locked;
            ident_data_out <= 16'h0000;
            if (ident_rd_in && ident_word_in == 8'(dsp_pkg::IDENT_REV_WORD)) begin
                ident_data_out <= master_rev;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= 32'h0000_0000;
            if (rd_in) begin
                case (addr_in)
                    dsp_pkg::REG_ERROR: rdata_out <= {24'h000000, error_out};
                    dsp_pkg::REG_STATUS: rdata_out <= {24'h000000, status_out};
                    dsp_pkg::REG_LOCK: rdata_out <= {24'h000000, 3'h0, attempts == 3'h0,
                        frozen, sec_max, locked, lock_enabled};
                    dsp_pkg::REG_REVISION: rdata_out <= {16'h0000, master_rev};
                    dsp_pkg::REG_FREEZE: rdata_out <= {31'h00000000, frozen};
                    default: rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // a cut sector never reaches exec: the handler just waits for the missing words
    a_abort_flags: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && do_abort |=>
        error_out[2] && status_out[0] && !status_out[7])
        else $error("abort flags wrong");
    a_attempt_dec: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && do_abort && attempts != 3'h0 && !power_on_in &&
        !hard_reset_in |=> attempts == $past(attempts) - 3'h1)
        else $error("attempt counter not decremented");
    a_expired_reject: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        is_cmd && attempts == 3'h0 |=> state == dsp_pkg::DSP_IDLE && error_out[2])
        else $error("expired drive accepted command");
    a_frozen_reject: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        is_cmd && frozen |=> state == dsp_pkg::DSP_IDLE && cmd_done_out)
        else $error("frozen drive accepted command");
    a_master_nolock: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        accepted && ident_master |=> lock_enabled == $past(lock_enabled))
        else $error("master set changed lock enable");
    a_user_nolock: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        accepted && !ident_master && !locked && !power_on_in && !hard_reset_in |=>
        lock_enabled && !locked)
        else $error("user set misbehaved");
    a_rev_guard: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        accepted && (rev_in == dsp_pkg::REV_INVALID_HI || rev_in == dsp_pkg::REV_INVALID_LO)
        |=> $stable(master_rev))
        else $error("invalid revision stored");
    a_max_master: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && !is_set && ident_master && sec_max |=> error_out[2])
        else $error("maximum level master unlock not rejected");
    a_user_disabled: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && !is_set && !ident_master && !lock_enabled |=>
        error_out[2])
        else $error("unlock with lock disabled not aborted");
    a_sector_len: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC |-> $past(word_idx) == 8'hff)
        else $error("executed before full sector");
    a_drq_status: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        is_cmd && !reject_early |=> status_out[dsp_pkg::ST_DRQ_BIT] && !cmd_done_out)
        else $error("accepted command did not ask for data");
    a_early_done: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        is_cmd && reject_early |=> cmd_done_out && status_out[dsp_pkg::ST_ERR_BIT] &&
        !status_out[dsp_pkg::ST_BUSY_BIT])
        else $error("early abort not reported");
    a_unlock_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && !is_set && unlock_ok && !power_on_in && !hard_reset_in
        |=> !locked)
        else $error("successful unlock left the drive locked");

    c_set_user: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        accepted && !ident_master);
    c_unlock_ok: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && !is_set && unlock_ok);
    c_expired: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        attempts == 3'h0);
    c_early_abort: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        is_cmd && reject_early);
    c_master_unlock: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state == dsp_pkg::DSP_EXEC && !is_set && ident_master && unlock_ok);
endmodule
